// *** rtl/feq_pkg.sv ***
// Purpose: Shared constants and types for the nine-tap equalizer filter
// Assumes: Register index times four is the byte address on the bus
// Notes: Coefficient tap k multiplies the sample delayed by k samples
`default_nettype none
package feq_pkg;
   localparam int NTAP = 9;
   localparam int CENTRE = 4;
   localparam int SW = 12;
   localparam int CW_SIDE = 12;
   localparam int CW_CTR = 18;
   localparam int ACC_W = 36;
   localparam int FRAC = 16;
   localparam int MLEN = 10;
   localparam int IDX_W = 12;
   localparam int ADDR_W = 14;
   localparam int SIDE_REG_W = 16;
   localparam int CTR_REG_W = 24;

   // Register indices
   localparam logic [11:0] IDX_CFG = 12'h400;
   localparam logic [11:0] IDX_SER = 12'h401;
   localparam logic [11:0] IDX_STAT = 12'h402;
   localparam logic [11:0] IDX_TAP0_COEFF = 12'h418;
   localparam logic [11:0] IDX_TAP1_COEFF = 12'h41a;
   localparam logic [11:0] IDX_TAP2_COEFF = 12'h41c;
   localparam logic [11:0] IDX_TAP3_COEFF = 12'h41e;
   localparam logic [11:0] IDX_CENTER_TAP_COEFF = 12'h420;
   localparam logic [11:0] IDX_TAP5_COEFF = 12'h423;
   localparam logic [11:0] IDX_TAP6_COEFF = 12'h425;
   localparam logic [11:0] IDX_TAP7_COEFF = 12'h427;
   localparam logic [11:0] IDX_TAP8_COEFF = 12'h429;
   localparam logic [11:0] IDX_B_BASE = 12'h430;
   localparam logic [11:0] IDX_A_TAP [NTAP] = '{IDX_TAP0_COEFF, IDX_TAP1_COEFF,
      IDX_TAP2_COEFF, IDX_TAP3_COEFF, IDX_CENTER_TAP_COEFF, IDX_TAP5_COEFF,
      IDX_TAP6_COEFF, IDX_TAP7_COEFF, IDX_TAP8_COEFF};

   // Config field positions and values
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_SCW_LSB = 2;
   localparam int CFG_MERGE_BIT = 5;
   localparam int CFG_SHARE_BIT = 6;
   localparam int CFG_W = 7;
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_SAT_BIT = 1;
   localparam logic [1:0] MODE_ENABLED = 2'h2;
   localparam logic [2:0] SCW_MAX = 3'h6;
   localparam logic [6:0] CFG_RESET = 7'h00;
   localparam logic [23:0] COEFF_RESET = 24'h00_0000;
   localparam logic signed [11:0] SAMPLE_MAX = 12'h7ff;
   localparam logic signed [11:0] SAMPLE_MIN = 12'h800;

   typedef struct packed {
      logic signed [11:0] a;
      logic signed [11:0] b;
   } feq_pair_t;

   typedef struct packed {
      logic hit;
      logic ch;
      logic [3:0] tap;
   } feq_sel_t;
endpackage : feq_pkg
`default_nettype wire

// *** rtl/feq_mac.sv ***
// Purpose: Nine-tap multiply-accumulate with saturation to sample width
// Assumes: Window index 0 is the newest sample
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ns
`default_nettype none
module feq_mac
   import feq_pkg::*;
(
   input wire logic [NTAP-1:0][SW-1:0] win,
   input wire logic [NTAP-1:0][CW_CTR-1:0] coef,
   input wire logic [2:0] scw,
   output logic signed [SW-1:0] result,
   output logic sat
);
   logic signed [ACC_W-1:0] prod [NTAP];
   logic signed [ACC_W-1:0] sum;
   logic signed [ACC_W-1:0] scaled;
   logic [2:0] shift;

   // Values above six are clamped rather than overflowing the accumulator
   assign shift = (scw > SCW_MAX) ? SCW_MAX : scw;

   genvar k;
   generate
      for (k = 0; k < NTAP; k++)
      begin : g_tap
         if (k == CENTRE)
         begin : g_ctr
            // Operands widened first so the product is never cut to operand width
            assign prod[k] = ACC_W'($signed(win[k]))
               * ACC_W'($signed(coef[k][CW_CTR-1:0]));
         end
         else
         begin : g_side
            // Side LSB is 2^(scw-16), so shift left by scw ahead of the common 2^-16
            assign prod[k] = (ACC_W'($signed(win[k]))
               * ACC_W'($signed(coef[k][CW_SIDE-1:0]))) <<< shift;
         end
      end
   endgenerate

   always_comb
   begin
      sum = '0;
      for (int i = 0; i < NTAP; i++)
      begin
         sum = sum + prod[i];
      end
      scaled = sum >>> FRAC;
      sat = 1'b0;
      if (scaled > ACC_W'(SAMPLE_MAX))
      begin
         result = SAMPLE_MAX;
         sat = 1'b1;
      end
      else if (scaled < ACC_W'(SAMPLE_MIN))
      begin
         result = SAMPLE_MIN;
         sat = 1'b1;
      end
      else
      begin
         result = scaled[SW-1:0];
      end
   end
endmodule : feq_mac
`default_nettype wire

// *** rtl/feq_top.sv ***
// Purpose: Coefficient registers and two-channel nine-tap equalizer filter
// Assumes: Samples come from logic on clk; Avalon-MM slave with byte addresses
// Notes: Every access takes two cycles; output follows input by two cycles
`timescale 1ns/1ns
`default_nettype none
module feq_top
   import feq_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic in_valid,
   input wire feq_pair_t in_sample,
   output logic out_valid,
   output feq_pair_t out_sample,
   output logic serial_output_enable,
   output logic filter_active
);
   logic [23:0] coeff_ff [2][NTAP];
   logic [CFG_W-1:0] cfg_ff;
   logic ser_ff;
   logic sat_ff;
   logic wait_ff;
   logic [31:0] rdata_ff;
   logic signed [SW-1:0] line_a_ff [NTAP];
   logic signed [SW-1:0] line_b_ff [NTAP];
   logic signed [SW-1:0] line_m_ff [MLEN];
   logic vld1_ff;
   logic out_valid_ff;
   feq_pair_t out_ff;
   logic active_ff;

   logic [IDX_W-1:0] idx;
   feq_sel_t sel;
   logic access;
   logic [31:0] wmask;
   logic [31:0] cur;
   logic [31:0] merged;
   logic enabled;
   logic merge;
   logic share;
   logic [NTAP-1:0][SW-1:0] win_a;
   logic [NTAP-1:0][SW-1:0] win_b;
   logic [NTAP-1:0][CW_CTR-1:0] coef_a;
   logic [NTAP-1:0][CW_CTR-1:0] coef_b;
   logic signed [SW-1:0] res_a;
   logic signed [SW-1:0] res_b;
   logic sat_a;
   logic sat_b;
   logic nxt_sat;

   // Maps a register index to a coefficient slot
   function automatic feq_sel_t decode_coeff(input logic [IDX_W-1:0] i);
      feq_sel_t s;
      s = '0;
      for (int t = 0; t < NTAP; t++)
      begin
         if (i == IDX_A_TAP[t])
         begin
            s.hit = 1'b1;
            s.ch = 1'b0;
            s.tap = 4'(t);
         end
         if (i == IDX_B_BASE + IDX_W'(t))
         begin
            s.hit = 1'b1;
            s.ch = 1'b1;
            s.tap = 4'(t);
         end
      end
      return s;
   endfunction : decode_coeff

   assign idx = avs_address[ADDR_W-1:2];
   assign sel = decode_coeff(idx);
   assign access = (avs_read | avs_write) & ~wait_ff;
   assign enabled = (cfg_ff[CFG_MODE_LSB +: 2] == MODE_ENABLED);
   assign merge = cfg_ff[CFG_MERGE_BIT];
   assign share = cfg_ff[CFG_SHARE_BIT];

   always_comb
   begin
      for (int b = 0; b < 4; b++)
      begin
         wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
      end
      cur = 32'h0000_0000;
      if (sel.hit)
      begin
         cur = {8'h00, coeff_ff[sel.ch][sel.tap]};
      end
      else if (idx == IDX_CFG)
      begin
         cur = {25'h000_0000, cfg_ff};
      end
      else if (idx == IDX_SER)
      begin
         cur = {31'h0000_0000, ser_ff};
      end
      else if (idx == IDX_STAT)
      begin
         cur = {30'h0000_0000, sat_ff, active_ff};
      end
      merged = (cur & ~wmask) | (avs_writedata & wmask);
   end

   // Bus handshake: wait high on the first cycle, low on the second
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end
      else if ((avs_read | avs_write) & wait_ff)
      begin
         wait_ff <= 1'b0;
         rdata_ff <= avs_read ? cur : 32'h0000_0000;
      end
      else
      begin
         wait_ff <= 1'b1;
      end
   end

   // Coefficient store; width follows the tap, reserved bits stored as zero
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int c = 0; c < 2; c++)
         begin
            for (int t = 0; t < NTAP; t++)
            begin
               coeff_ff[c][t] <= COEFF_RESET;
            end
         end
      end
      else if (access & avs_write & sel.hit)
      begin
         if (sel.tap == 4'(CENTRE))
         begin
            coeff_ff[sel.ch][sel.tap] <= merged[CTR_REG_W-1:0];
         end
         else
         begin
            coeff_ff[sel.ch][sel.tap] <= {8'h00, merged[SIDE_REG_W-1:0]};
         end
      end
   end

   // Settings are not locked while the serial output runs; software must avoid it
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cfg_ff <= CFG_RESET;
         ser_ff <= 1'b0;
      end
      else if (access & avs_write)
      begin
         if (idx == IDX_CFG)
         begin
            cfg_ff <= merged[CFG_W-1:0];
         end
         if (idx == IDX_SER)
         begin
            ser_ff <= merged[0];
         end
      end
   end

   // Sticky saturation flag; a new event beats a write-one clear
   always_comb
   begin
      nxt_sat = sat_ff;
      if (access & avs_write & (idx == IDX_STAT) & avs_byteenable[0]
         & avs_writedata[STAT_SAT_BIT])
      begin
         nxt_sat = 1'b0;
      end
      if (vld1_ff & enabled & (sat_a | sat_b))
      begin
         nxt_sat = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sat_ff <= 1'b0;
      end
      else
      begin
         sat_ff <= nxt_sat;
      end
   end

   // Delay lines: separate per channel, plus one line for the merged stream
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int k = 0; k < NTAP; k++)
         begin
            line_a_ff[k] <= '0;
            line_b_ff[k] <= '0;
         end
         for (int k = 0; k < MLEN; k++)
         begin
            line_m_ff[k] <= '0;
         end
      end
      else if (in_valid)
      begin
         line_a_ff[0] <= in_sample.a;
         line_b_ff[0] <= in_sample.b;
         for (int k = 1; k < NTAP; k++)
         begin
            line_a_ff[k] <= line_a_ff[k-1];
            line_b_ff[k] <= line_b_ff[k-1];
         end
         // Sample a precedes sample b in the merged stream
         line_m_ff[0] <= in_sample.b;
         line_m_ff[1] <= in_sample.a;
         for (int k = 2; k < MLEN; k++)
         begin
            line_m_ff[k] <= line_m_ff[k-2];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NTAP; g++)
      begin : g_win
         assign win_a[g] = merge ? line_m_ff[g+1] : line_a_ff[g];
         assign win_b[g] = merge ? line_m_ff[g] : line_b_ff[g];
         // Taps one to four of channel A sit at window positions one to four
         assign coef_a[g] = coeff_ff[0][g][CW_CTR-1:0];
         assign coef_b[g] = (share | merge) ? coeff_ff[0][g][CW_CTR-1:0]
            : coeff_ff[1][g][CW_CTR-1:0];
      end
   endgenerate

   feq_mac u_mac_a (
      .win(win_a),
      .coef(coef_a),
      .scw(cfg_ff[CFG_SCW_LSB +: 3]),
      .result(res_a),
      .sat(sat_a)
   );

   feq_mac u_mac_b (
      .win(win_b),
      .coef(coef_b),
      .scw(cfg_ff[CFG_SCW_LSB +: 3]),
      .result(res_b),
      .sat(sat_b)
   );

   // Output stage; disabled mode passes the newest sample of each window
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         vld1_ff <= 1'b0;
         out_valid_ff <= 1'b0;
         out_ff <= '0;
         active_ff <= 1'b0;
      end
      else
      begin
         vld1_ff <= in_valid;
         out_valid_ff <= vld1_ff;
         active_ff <= enabled;
         if (vld1_ff)
         begin
            out_ff.a <= enabled ? res_a : $signed(win_a[0]);
            out_ff.b <= enabled ? res_b : $signed(win_b[0]);
         end
      end
   end

   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign out_valid = out_valid_ff;
   assign out_sample = out_ff;
   assign serial_output_enable = ser_ff;
   assign filter_active = active_ff;
endmodule : feq_top
`default_nettype wire

// *** bench/feq_src.sv ***
// Purpose: Sample source in place of the converter core
// Assumes: One pair per request, sent on the edge after it
// Notes: Idle data flips so a stale pair never looks valid
`timescale 1ns/1ns
`default_nettype none
module feq_src
   import feq_pkg::*;
(
   input wire logic clk,
   input wire logic req,
   input wire feq_pair_t pair,
   output logic in_valid,
   output feq_pair_t in_sample
);
   initial
   begin
      in_valid = 1'b0;
      in_sample = '0;
   end
   always @(posedge clk)
   begin
      in_valid <= req;
      in_sample <= req ? pair : ~in_sample;
   end
endmodule : feq_src
`default_nettype wire

// *** bench/feq_top_checker.sv ***
// Purpose: Port properties of the equalizer block
// Assumes: One clock domain, reset active low
// Notes: Filter arithmetic is judged in the bench
`timescale 1ns/1ns
`default_nettype none
module feq_top_checker
   import feq_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic in_valid,
   input wire feq_pair_t in_sample,
   input wire logic out_valid,
   input wire feq_pair_t out_sample,
   input wire logic filter_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic [IDX_W-1:0] idx = avs_address[13:2];
   wire logic rd_done = avs_read && !avs_waitrequest;
   wire logic cfg_wr = avs_write && !avs_waitrequest && idx == IDX_CFG && avs_byteenable[0];
   logic [1:0] mode_ff;
   // Kept because the active flag lags the write
   always_ff @(posedge clk)
   begin
      if (cfg_wr)
         mode_ff <= avs_writedata[1:0];
   end
   property p_one_wait;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait low too long");
   property p_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_lat;
      out_valid == $past(in_valid, 2);
   endproperty
   a_lat: assert property (p_lat) else $error("output latency");
   property p_pass;
      in_valid && !filter_active ##1 !filter_active [*2] |-> out_sample == $past(in_sample, 2);
   endproperty
   a_pass: assert property (p_pass) else $error("sample altered");
   property p_active;
      cfg_wr |-> ##2 filter_active == (mode_ff == MODE_ENABLED);
   endproperty
   a_active: assert property (p_active) else $error("active flag");
   property p_side_rd;
      rd_done && (idx == IDX_TAP1_COEFF || idx == IDX_TAP2_COEFF || idx == IDX_TAP3_COEFF)
         |-> avs_readdata[31:16] == 16'h0000;
   endproperty
   a_side_rd: assert property (p_side_rd) else $error("side width");
   property p_ctr_rd;
      rd_done && idx == IDX_CENTER_TAP_COEFF |-> avs_readdata[31:24] == 8'h00;
   endproperty
   a_ctr_rd: assert property (p_ctr_rd) else $error("centre width");
   property p_hold;
      !out_valid |-> $stable(out_sample);
   endproperty
   a_hold: assert property (p_hold) else $error("output moved");
   c_enable: cover property (cfg_wr && avs_writedata[1:0] == MODE_ENABLED);
   c_filtered: cover property (out_valid && filter_active);
   c_read: cover property (rd_done);
endmodule : feq_top_checker
bind feq_top feq_top_checker feq_top_checker_i (.*);
`default_nettype wire

// *** bench/fir_equalizer_coefficients_bench.sv ***
// Purpose: Register and sample path bench for the equalizer
// Assumes: All byte lanes enabled on every access
// Notes: Impulse 0x400 at side weight 6 returns each side tap value, and the centre tap value divided by 64
`timescale 1ns/1ns
`default_nettype none
module fir_equalizer_coefficients_bench
   import feq_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic in_valid;
   logic out_valid;
   logic serial_output_enable;
   logic filter_active;
   logic req = 1'b0;
   feq_pair_t pair = '0;
   feq_pair_t in_sample;
   feq_pair_t out_sample;
   logic [31:0] rd;
   logic [11:0] resp [10] = '{12'h000, 12'h005, 12'h006, 12'hff9, 12'hfc0, 12'h000,
      12'h000, 12'h000, 12'h000, 12'h000};
   int failures = 0;
   int num_checks = 0;
   always #10 clk = ~clk;
   feq_top feq_top_i (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .in_valid, .in_sample,
      .out_valid, .out_sample, .serial_output_enable, .filter_active);
   feq_src feq_src_i (.clk, .req, .pair, .in_valid, .in_sample);
   task automatic report_and_stop;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic await(ref logic sig, input logic lvl);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (sig !== lvl && n < 20);
      if (sig !== lvl)
      begin
         failures++;
         report_and_stop;
      end
   endtask : await
   // Idle edge at the end so the next call never reassigns in the same step
   task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      await(avs_waitrequest, 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic send(input logic [11:0] a, input logic [11:0] b, input feq_pair_t exp);
      req <= 1'b1;
      pair <= {a, b};
      @(posedge clk);
      req <= 1'b0;
      await(out_valid, 1'b1);
      chk({8'h00, out_sample}, {8'h00, exp});
   endtask : send
   function automatic logic [11:0] imp(input int i);
      return i == 0 ? 12'h400 : 12'h000;
   endfunction : imp
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Coefficients still zero, so enabled output is zero
      for (logic [2:0] m = 0; m < 4; m++)
      begin
         bus(1'b1, IDX_CFG, {27'h000_0000, 3'h6, m[1:0]});
         send(12'h123, 12'h456, m == 2 ? 24'h00_0000 : 24'h12_3456);
         chk(32'(filter_active), 32'(m == 2));
      end
      for (int i = 1; i < 5; i++)
      begin
         bus(1'b0, IDX_A_TAP[i], '0);
         chk(rd, '0);
         bus(1'b1, IDX_A_TAP[i], 32'hffff_ffff);
         bus(1'b0, IDX_A_TAP[i], '0);
         chk(rd, i == 4 ? 32'h00ff_ffff : 32'h0000_ffff);
      end
      bus(1'b1, 12'h3ff, 32'hffff_ffff);
      bus(1'b0, 12'h3ff, '0);
      chk(rd, '0);
      bus(1'b1, IDX_TAP1_COEFF, 32'h0000_0005);
      bus(1'b1, IDX_TAP2_COEFF, 32'h0000_0006);
      bus(1'b1, IDX_TAP3_COEFF, 32'h0000_fff9);
      bus(1'b1, IDX_CENTER_TAP_COEFF, 32'h00ff_f000);
      bus(1'b1, IDX_CFG, '0);
      for (int i = 0; i < 9; i++)
         send(12'h000, 12'h000, '0);
      bus(1'b1, IDX_CFG, 32'h0000_005a);
      for (int i = 0; i < 9; i++)
         send(imp(i), imp(i), {resp[i], resp[i]});
      bus(1'b1, IDX_CFG, 32'h0000_003a);
      for (int i = 0; i < 5; i++)
         send(imp(i), 12'h000, {resp[2 * i], resp[2 * i + 1]});
      bus(1'b1, IDX_CFG, 32'h0000_001a);
      for (int i = 0; i < 5; i++)
         send(12'h000, imp(i), '0);
      // Own B centre tap pushes a full-scale sample past the output range
      bus(1'b1, IDX_B_BASE + 12'(CENTRE), 32'h0001_ffff);
      for (int i = 0; i < 5; i++)
         send(12'h000, i == 0 ? 12'h7ff : 12'h000, i == 4 ? 24'h00_07ff : '0);
      bus(1'b0, IDX_STAT, '0);
      chk(rd, 32'h0000_0003);
      bus(1'b1, IDX_STAT, 32'h0000_0002);
      bus(1'b0, IDX_STAT, '0);
      chk(rd, 32'h0000_0001);
      // Settings are done before the serial output goes live
      bus(1'b1, IDX_SER, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk(32'(serial_output_enable), 32'h0000_0001);
      report_and_stop;
   end
endmodule : fir_equalizer_coefficients_bench
`default_nettype wire
